// File: src/rcip_pkg.sv
/*
 * Shared constants, register map and carrier types for the reset, bus-phase
 * clock and interrupt pin block. Assumes a single 50 MHz clock (mclk), which
 * stands in for the oscillator input, and an AXI4-Lite register master.
 */
// Notes on behaviour
// - Reset pin: input, and open-drain failure output
// - Pin high within two phases: internal
// - Bus-phase clock is oscillator divided by four
// - Low half processing, high half data access
// - Stop mode halts all clocks and output
// - Clock output may be disabled, some always on
// - Maskable line: falling edge or low level
// - Reset selects level triggering for maskable line
// - Reset sets nonmaskable mask; software only clears
// - Nonmaskable line is low-level sensitive
// - Held line retriggers when mask bit clears
package rcip_pkg;

	// Register byte offsets
	localparam int            ADDR_W      = 8;
	localparam logic [7:0]    OFS_CTRL    = 8'h00;
	localparam logic [7:0]    OFS_CFLAGS  = 8'h04;
	localparam logic [7:0]    OFS_STATUS  = 8'h08;
	localparam logic [7:0]    OFS_MASK    = 8'h0C;
	localparam logic [7:0]    OFS_STATE   = 8'h10;

	// Control register fields
	localparam int            CTRL_EDGE   = 0;
	localparam int            CTRL_STOP   = 1;
	localparam int            CTRL_CLKEN  = 2;
	localparam int            CFLAG_XMASK = 0;

	// Reset values
	localparam logic          RST_EDGE    = 1'b0;
	localparam logic          RST_STOP    = 1'b0;
	localparam logic          RST_CLKEN   = 1'b1;
	localparam logic          RST_XMASK   = 1'b1;

	// Clock division, and reset timing in bus-phase cycles
	localparam logic [1:0]    PH_LAST     = 2'h3;
	localparam int            PH_HI_BIT   = 1;
	localparam logic [2:0]    DRIVE_E     = 3'h4;
	localparam logic [2:0]    INT_E_LIM   = 3'h2;

	// AXI responses
	localparam logic [1:0]    RESP_OKAY   = 2'h0;
	localparam logic [1:0]    RESP_SLVERR = 2'h2;

	// Sticky event layout, shared by status and mask
	typedef struct packed {
		logic irq_edge;
		logic rst_ext;
		logic rst_int;
		logic wdog;
		logic clkmon;
	} rcip_evt_t;

	// Synchronised pin levels
	typedef struct packed {
		logic nonmaskable_interrupt_line;
		logic irq;
		logic rst;
	} rcip_pins_t;

	typedef enum logic [1:0] {RP_IDLE, RP_DRIVE, RP_WAIT} rcip_rp_state_t;

endpackage : rcip_pkg

// File: src/rcip_sync3.sv
/*
 * Three-stage pin synchroniser. A new level is accepted only once the second
 * and third stages agree. Assumes asynchronous pins, idle high.
 */
`timescale 1ns/1ps
`default_nettype none
module rcip_sync3
	import rcip_pkg::*;
(
	input  wire logic       mclk,     // System clock
	input  wire logic       reset_n,  // Async reset, active low
	input  wire rcip_pins_t pins_a,   // Raw pin levels
	output rcip_pins_t      pins_s    // Filtered levels
);
	rcip_pins_t s1_r;
	rcip_pins_t s2_r;
	rcip_pins_t s3_r;

	////////////////////////////////////////////////////////////////////////
	// Stage one feeds stage two only, to contain metastability
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s1_r   <= '1;
			s2_r   <= '1;
			s3_r   <= '1;
			pins_s <= '1;
		end
		else
		begin
			s1_r <= pins_a;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int i = 0; i < $bits(rcip_pins_t); i++)
				if (s2_r[i] == s3_r[i])
					pins_s[i] <= s3_r[i];
		end
	end
endmodule : rcip_sync3
`default_nettype wire

// File: src/rcip_top.sv
/*
 * Reset pin, bus-phase clock and interrupt pin logic with an AXI4-Lite
 * register slave. Assumes mclk is the oscillator input, that failure
 * strobes come from same-clock monitors, and that the core supplies its
 * interrupt mask bit and acknowledge.
 */
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module rcip_top
	import rcip_pkg::*;
#(
	parameter bit ALWAYS_ON = 1'b0            // Clock output cannot be disabled
)(
	input  wire logic              mclk,          // Oscillator input clock
	input  wire logic              reset_n,       // Async reset, active low
	input  wire logic [ADDR_W-1:0] s_awaddr,      // Write address
	input  wire logic              s_awvalid,     // Write address valid
	output logic                   s_awready,     // Write address ready
	input  wire logic [31:0]       s_wdata,       // Write data
	input  wire logic [3:0]        s_wstrb,       // Byte enables
	input  wire logic              s_wvalid,      // Write data valid
	output logic                   s_wready,      // Write data ready
	output logic [1:0]             s_bresp,       // Write response
	output logic                   s_bvalid,      // Write response valid
	input  wire logic              s_bready,      // Write response ready
	input  wire logic [ADDR_W-1:0] s_araddr,      // Read address
	input  wire logic              s_arvalid,     // Read address valid
	output logic                   s_arready,     // Read address ready
	output logic [31:0]            s_rdata,       // Read data
	output logic [1:0]             s_rresp,       // Read response
	output logic                   s_rvalid,      // Read data valid
	input  wire logic              s_rready,      // Read data ready
	input  wire logic              rst_pin_i,     // Reset pin level
	output logic                   rst_pin_o,     // Reset pin drive value
	output logic                   rst_pin_oe,    // Reset pin pulled low
	input  wire logic              clkmon_fail,   // Clock monitor failure strobe
	input  wire logic              wdog_fail,     // Watchdog timeout strobe
	output logic                   sys_rst_n,     // Device reset, active low
	output logic                   bus_phase_clk, // Bus-phase clock pin
	output logic                   access_phase,  // High half: data access
	input  wire logic              irq_n,         // Maskable line, active low
	input  wire logic              nonmaskable_interrupt_line_n,        // Nonmaskable line, active low
	input  wire logic              cpu_i_mask,    // Core interrupt mask bit
	input  wire logic              irq_ack,       // Core took maskable request
	output logic                   irq_req,       // Maskable request to core
	output logic                   nmi_req,       // Nonmaskable request to core
	output logic                   intr           // Status interrupt, level
);
	rcip_pins_t     pins_s;
	logic           rst_d_r, irq_d_r;
	logic           edge_r, stop_r, clken_r, xmask_r, pend_r;
	logic [1:0]     ph_r, ph_nxt;
	logic           eout_r;
	logic [2:0]     cnt_r;
	rcip_rp_state_t rp_r;
	rcip_evt_t      status_r, mask_r, ev;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation
	rcip_sync3 u_sync (
		.mclk    (mclk),
		.reset_n (reset_n),
		.pins_a  ({nonmaskable_interrupt_line_n, irq_n, rst_pin_i}),
		.pins_s  (pins_s)
	);

	wire soft_rst = !pins_s.rst;          // Pin low re-initialises the device
	wire rst_rise = pins_s.rst && !rst_d_r;
	wire irq_fall = !pins_s.irq && irq_d_r;
	wire e_end    = !stop_r && (ph_r == PH_LAST);
	wire fail     = clkmon_fail || wdog_fail;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_d_r <= 1'b1;
			irq_d_r <= 1'b1;
		end
		else
		begin
			rst_d_r <= pins_s.rst;
			irq_d_r <= pins_s.irq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path: address and data may arrive in either order
	logic              aw_v_r, w_v_r;
	logic [ADDR_W-1:0] aw_a_r;
	logic [7:0]        w_d_r;
	logic              w_s_r;

	assign s_awready = !aw_v_r && !s_bvalid;
	assign s_wready  = !w_v_r && !s_bvalid;
	wire   do_wr     = aw_v_r && w_v_r;
	wire   wr_ok     = do_wr && w_s_r;
	wire   wr_ctrl   = wr_ok && (aw_a_r == OFS_CTRL);
	wire   wr_cflag  = wr_ok && (aw_a_r == OFS_CFLAGS);
	wire   wr_mask   = wr_ok && (aw_a_r == OFS_MASK);
	wire   wr_map    = (aw_a_r == OFS_CTRL) || (aw_a_r == OFS_CFLAGS) || (aw_a_r == OFS_STATUS)
	                   || (aw_a_r == OFS_MASK) || (aw_a_r == OFS_STATE);

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			aw_v_r   <= 1'b0;
			w_v_r    <= 1'b0;
			aw_a_r   <= '0;
			w_d_r    <= 8'h00;
			w_s_r    <= 1'b0;
			s_bvalid <= 1'b0;
			s_bresp  <= RESP_OKAY;
		end
		else
		begin
			if (s_awvalid && s_awready)
			begin
				aw_v_r <= 1'b1;
				aw_a_r <= s_awaddr;
			end
			if (s_wvalid && s_wready)
			begin
				w_v_r <= 1'b1;
				w_d_r <= s_wdata[7:0];
				w_s_r <= s_wstrb[0];
			end
			if (do_wr)
			begin
				aw_v_r   <= 1'b0;
				w_v_r    <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_bready)
				s_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path, one cycle to the answer
	assign s_arready = !s_rvalid;
	wire   rd_hs     = s_arvalid && s_arready;
	wire   rd_stat   = rd_hs && (s_araddr == OFS_STATUS);
	wire [31:0] rd_mux =
		(s_araddr == OFS_CTRL)   ? {29'h0, clken_r, stop_r, edge_r} :
		(s_araddr == OFS_CFLAGS) ? {31'h0, xmask_r} :
		(s_araddr == OFS_STATUS) ? {27'h0, status_r} :
		(s_araddr == OFS_MASK)   ? {27'h0, mask_r} :
		{25'h0, pend_r, rst_pin_oe, ph_r[PH_HI_BIT], pins_s.nonmaskable_interrupt_line, pins_s.irq, pins_s.rst, sys_rst_n};
	wire rd_map = (s_araddr == OFS_CTRL) || (s_araddr == OFS_CFLAGS) || (s_araddr == OFS_STATUS)
	              || (s_araddr == OFS_MASK) || (s_araddr == OFS_STATE);

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_rvalid <= 1'b0;
			s_rdata  <= 32'h0000_0000;
			s_rresp  <= RESP_OKAY;
		end
		else if (rd_hs)
		begin
			s_rvalid <= 1'b1;
			s_rdata  <= rd_map ? rd_mux : 32'h0000_0000;
			s_rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_rready)
			s_rvalid <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Control bits; a low reset pin forces their start-up values
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			edge_r  <= RST_EDGE;
			stop_r  <= RST_STOP;
			clken_r <= RST_CLKEN;
			xmask_r <= RST_XMASK;
		end
		else if (soft_rst)
		begin
			edge_r  <= RST_EDGE;
			stop_r  <= RST_STOP;
			clken_r <= RST_CLKEN;
			xmask_r <= RST_XMASK;
		end
		else
		begin
			if (wr_ctrl)
			begin
				edge_r  <= w_d_r[CTRL_EDGE];
				stop_r  <= w_d_r[CTRL_STOP];
				clken_r <= w_d_r[CTRL_CLKEN];
			end
			// Software can only clear the mask, never set it again
			if (wr_cflag && !w_d_r[CFLAG_XMASK])
				xmask_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus-phase clock: divide by four, frozen in stop mode
	assign ph_nxt       = stop_r ? ph_r : ph_r + 2'h1;
	assign access_phase = ph_r[PH_HI_BIT];

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ph_r   <= 2'h0;
			eout_r <= 1'b0;
		end
		else
		begin
			ph_r   <= ph_nxt;
			eout_r <= !stop_r && (ALWAYS_ON || clken_r) && ph_nxt[PH_HI_BIT];
		end
	end
	assign bus_phase_clk = eout_r;

	////////////////////////////////////////////////////////////////////////
	// Reset pin: drive low on failure, then time the release
	assign rst_pin_o  = 1'b0;
	assign rst_pin_oe = (rp_r == RP_DRIVE);
	assign sys_rst_n  = pins_s.rst;
	wire   cause_int  = (rp_r == RP_WAIT) && (cnt_r < INT_E_LIM);

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rp_r  <= RP_IDLE;
			cnt_r <= 3'h0;
		end
		else
		begin
			case (rp_r)
				RP_IDLE:
				begin
					cnt_r <= 3'h0;
					if (fail)
						rp_r <= RP_DRIVE;
				end
				RP_DRIVE:
				begin
					if (e_end)
						cnt_r <= cnt_r + 3'h1;
					if (e_end && (cnt_r == DRIVE_E - 3'h1))
					begin
						rp_r  <= RP_WAIT;
						cnt_r <= 3'h0;
					end
				end
				RP_WAIT:
				begin
					// Counter saturates: only below-limit matters
					if (e_end && (cnt_r < INT_E_LIM))
						cnt_r <= cnt_r + 3'h1;
					if (rst_rise)
						rp_r <= RP_IDLE;
				end
				default:
					rp_r <= RP_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt lines; a held level line re-requests once unmasked
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			pend_r <= 1'b0;
		else if (!edge_r)
			pend_r <= 1'b0;
		else if (irq_fall)
			pend_r <= 1'b1;
		else if (irq_ack)
			pend_r <= 1'b0;
	end
	assign irq_req = !cpu_i_mask && (edge_r ? pend_r : !pins_s.irq);
	assign nmi_req = !xmask_r && !pins_s.nonmaskable_interrupt_line;

	////////////////////////////////////////////////////////////////////////
	// Sticky events; a new event wins over the read that clears
	assign ev.clkmon   = clkmon_fail;
	assign ev.wdog     = wdog_fail;
	assign ev.rst_int  = rst_rise && cause_int;
	assign ev.rst_ext  = rst_rise && !cause_int;
	assign ev.irq_edge = edge_r && irq_fall;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			status_r <= '0;
			mask_r   <= '0;
		end
		else
		begin
			status_r <= ev | (rd_stat ? '0 : status_r);
			if (wr_mask)
				mask_r <= w_d_r[$bits(rcip_evt_t)-1:0];
		end
	end
	assign intr = |(status_r & mask_r);

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence s_run3;
		!stop_r [*3];
	endsequence

	sequence s_fail_seen;
		fail && (rp_r == RP_IDLE);
	endsequence

	a_pin_pull: assert property (s_fail_seen |=> rst_pin_oe && !rst_pin_o)
		else $error("reset pin not pulled after failure");
	a_pull_hold: assert property ($rose(rst_pin_oe) |-> rst_pin_oe [*8])
		else $error("reset pin released too early");
	a_cause_int: assert property (rst_rise && cause_int |=> status_r.rst_int)
		else $error("internal reset not recorded");
	a_cause_ext: assert property (rst_rise && (rp_r == RP_IDLE)
		|=> status_r.rst_ext && !$rose(status_r.rst_int)) else $error("external reset misclassified");
	a_div_four: assert property ($rose(ph_r[PH_HI_BIT]) && !stop_r ##1 s_run3 |=> $rose(ph_r[PH_HI_BIT]))
		else $error("bus-phase clock not divide by four");
	a_stop_halt: assert property (stop_r ##1 stop_r |-> $stable(ph_r) && !bus_phase_clk)
		else $error("clock running in stop mode");
	a_clk_gate: assert property (!ALWAYS_ON && !clken_r ##1 !clken_r |-> !bus_phase_clk)
		else $error("clock output not disabled");
	a_irq_level: assert property (!edge_r && !pins_s.irq && !cpu_i_mask |-> irq_req)
		else $error("level request missed");
	a_irq_edge: assert property (edge_r && irq_fall && !soft_rst ##1 edge_r |-> pend_r)
		else $error("falling edge not latched");
	a_reset_mode: assert property (soft_rst |=> !edge_r && xmask_r)
		else $error("reset did not restore modes");
	a_nmi_block: assert property (xmask_r |-> !nmi_req)
		else $error("nonmaskable request while masked");
	a_xmask_stay: assert property (!xmask_r && !soft_rst |=> !xmask_r)
		else $error("nonmaskable mask set by software");
	a_nmi_level: assert property (!xmask_r && !pins_s.nonmaskable_interrupt_line |-> nmi_req)
		else $error("nonmaskable level request missed");
	a_retrigger: assert property (!edge_r && !pins_s.irq && $fell(cpu_i_mask) |-> irq_req)
		else $error("held line did not retrigger");
	a_sync_lag: assert property ($fell(irq_n) ##1 !irq_n [*4] |-> !pins_s.irq)
		else $error("synchroniser too slow");

endmodule : rcip_top
`default_nettype wire

// File: bench/rcip_far_model.sv
/*
 * Far side: reset line and two interrupt lines, open-drain with pull-ups.
 * Assumes strobes last one mclk cycle; an outside reset is held longer.
 */
`timescale 1ns/1ps
`default_nettype none
module rcip_far_model (
	input  wire logic mclk,       // Clock
	input  wire logic rst_pin_oe, // Device pulls reset line
	input  wire logic rst_pin_o,  // Device drive value on reset line
	input  wire logic ext_rst,    // Outside circuit holds reset low
	input  wire logic slow,       // Stretch reset release
	input  wire logic irq_go,     // Source raises request
	input  wire logic irq_ack,    // Core acknowledge
	input  wire logic nonmaskable_interrupt_line_src,   // Nonmaskable source active
	output logic      rst_pin_i,  // Reset line level
	output logic      irq_n,      // Shared maskable line
	output logic      nonmaskable_interrupt_line_n      // Shared nonmaskable line
);
	logic       hold_r = 1'b0;
	logic       oe_d_r = 1'b0;
	logic [3:0] str_r  = 4'h0;
	////////////////////////////////////////////////////////////////
	// Pull-ups win once every driver lets go
	assign rst_pin_i = !((rst_pin_oe && !rst_pin_o) || ext_rst || str_r != 4'h0 || (oe_d_r && slow));
	assign irq_n     = !hold_r;
	assign nonmaskable_interrupt_line_n    = !nonmaskable_interrupt_line_src;
	// Slow release mimics an outside reset circuit holding on
	always_ff @(posedge mclk)
	begin
		oe_d_r <= rst_pin_oe;
		if (oe_d_r && !rst_pin_oe && slow)
			str_r <= 4'hC;
		else if (str_r != 4'h0)
			str_r <= str_r - 4'h1;
		if (irq_go)
			hold_r <= 1'b1;
		else if (irq_ack)
			hold_r <= 1'b0;
	end
endmodule : rcip_far_model
`default_nettype wire

// File: bench/reset_clock_interrupt_pins_bench.sv
/*
 * Self-checking bench for rcip_top with AXI4-Lite master tasks.
 * Assumes the far-side model and a 50 MHz mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module reset_clock_interrupt_pins_bench;
	import rcip_pkg::*;
	logic        mclk = 0, reset_n = 0;
	logic [7:0]  s_awaddr = 0, s_araddr = 0;
	logic [31:0] s_wdata = 0, s_rdata, d, q;
	logic [3:0]  s_wstrb = 0;
	logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
	logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, low;
	logic [1:0]  s_bresp, s_rresp, r;
	logic        rst_pin_i, rst_pin_o, rst_pin_oe, sys_rst_n, bus_phase_clk, access_phase;
	logic        clkmon_fail = 0, wdog_fail = 0, cpu_i_mask = 1, irq_ack = 0;
	logic        irq_n, nonmaskable_interrupt_line_n, irq_req, nmi_req, intr;
	logic        slow = 0, irq_go = 0, nonmaskable_interrupt_line_src = 0, ext_rst = 0;
	int          errors = 0, n_checks = 0, hi, ri, mm;
	integer      seed = 32'h474998C9;
	// Strobe selectors for pulse: request, acknowledge, watchdog, clock monitor
	localparam logic [3:0] P_GO = 4'h1, P_ACK = 4'h2, P_WD = 4'h4, P_CM = 4'h8;

	always #10 mclk = ~mclk;

	rcip_top DUT (.mclk, .reset_n, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
		.s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
		.s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .rst_pin_i, .rst_pin_o,
		.rst_pin_oe, .clkmon_fail, .wdog_fail, .sys_rst_n, .bus_phase_clk, .access_phase,
		.irq_n, .nonmaskable_interrupt_line_n, .cpu_i_mask, .irq_ack, .irq_req, .nmi_req, .intr);
	rcip_far_model far (.mclk, .rst_pin_oe, .rst_pin_o, .ext_rst, .slow, .irq_go, .irq_ack, .nonmaskable_interrupt_line_src,
		.rst_pin_i, .irq_n, .nonmaskable_interrupt_line_n);

	////////////////////////////////////////////////////////////////
	// Expected register images
	function automatic logic [31:0] ctl(input logic e, st, ce);
		ctl = 32'h0;
		ctl[CTRL_EDGE] = e;
		ctl[CTRL_STOP] = st;
		ctl[CTRL_CLKEN] = ce;
	endfunction : ctl
	function automatic logic [31:0] ev(input logic cm, wd, ri_, re, ie);
		rcip_evt_t e;
		e = '{ie, re, ri_, wd, cm};
		ev = {27'h0, e};
	endfunction : ev
	task automatic chk(input logic [31:0] g, e);
		n_checks++;
		if (g !== e)
		begin
			errors++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Handshakes are judged at the falling edge, acted on at the next rise
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] rs);
		logic ta, tw, tb;
		@(posedge mclk);
		s_awaddr <= a;
		s_wdata <= v;
		s_wstrb <= s;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do
		begin
			@(negedge mclk);
			ta = s_awvalid && s_awready;
			tw = s_wvalid && s_wready;
			tb = s_bvalid;
			rs = s_bresp;
			@(posedge mclk);
			if (ta)
				s_awvalid <= 1'b0;
			if (tw)
				s_wvalid <= 1'b0;
		end while (!tb);
		s_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic ta, tb;
		@(posedge mclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do
		begin
			@(negedge mclk);
			ta = s_arvalid && s_arready;
			tb = s_rvalid;
			v = s_rdata;
			rs = s_rresp;
			@(posedge mclk);
			if (ta)
				s_arvalid <= 1'b0;
		end while (!tb);
		s_rready <= 1'b0;
	endtask : rd
	task automatic pulse(input logic [3:0] w);
		@(posedge mclk);
		{clkmon_fail, wdog_fail, irq_ack, irq_go} <= w;
		@(posedge mclk);
		{clkmon_fail, wdog_fail, irq_ack, irq_go} <= 4'h0;
	endtask : pulse
	task automatic measure(output int h, rs, m);
		logic p;
		h = 0;
		rs = 0;
		m = 0;
		@(negedge mclk);
		p = bus_phase_clk;
		repeat (16)
		begin
			@(negedge mclk);
			h += bus_phase_clk;
			rs += (bus_phase_clk && !p);
			m += (bus_phase_clk !== access_phase);
			p = bus_phase_clk;
		end
	endtask : measure
	task finish_test;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test

	////////////////////////////////////////////////////////////////
	// Watchdog, far beyond the few hundred cycles the run needs
	initial
	begin
		#400000;
		errors++;
		finish_test;
	end

	initial
	begin
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		// Reset values and unmapped slot
		rd(OFS_CTRL, d, r);
		chk(d, ctl(RST_EDGE, RST_STOP, RST_CLKEN));
		rd(OFS_CFLAGS, d, r);
		chk(d, {31'h0, RST_XMASK});
		rd(OFS_STATE, d, r);
		chk(d & 32'hFFFF_FFEF, 32'h0000_000F);
		rd(8'h14, d, r);
		chk(r, RESP_SLVERR);
		wr(8'h14, 32'h1, 4'hF, r);
		chk(r, RESP_SLVERR);
		// Random mask traffic; a write without byte 0 must not land
		repeat (8)
		begin
			d = $random(seed);
			wr(OFS_MASK, d, 4'hF, r);
			wr(OFS_MASK, ~d, 4'hE, r);
			rd(OFS_MASK, q, r);
			chk(q, d & 32'h1F);
		end
		// Divide by four, access half high, stop and disable
		measure(hi, ri, mm);
		chk(ri, 4);
		chk(hi, 8);
		chk(mm, 0);
		wr(OFS_CTRL, ctl(0, 1, 1), 4'hF, r);
		measure(hi, ri, mm);
		chk(hi, 0);
		wr(OFS_CTRL, ctl(0, 0, 0), 4'hF, r);
		measure(hi, ri, mm);
		chk(hi, 0);
		wr(OFS_CTRL, ctl(0, 0, 1), 4'hF, r);
		// Nonmaskable line: blocked after reset, then unmaskable
		nonmaskable_interrupt_line_src <= 1'b1;
		repeat (6) @(negedge mclk);
		chk(nmi_req, 0);
		wr(OFS_CFLAGS, 32'h0, 4'hF, r);
		@(negedge mclk);
		chk(nmi_req, 1);
		wr(OFS_CFLAGS, 32'h1, 4'hF, r);
		@(negedge mclk);
		chk(nmi_req, 1);
		// Level mode: held line retriggers when core unmasks
		pulse(P_GO);
		repeat (6) @(negedge mclk);
		chk(irq_req, 0);
		@(posedge mclk);
		cpu_i_mask <= 1'b0;
		@(negedge mclk);
		chk(irq_req, 1);
		pulse(P_ACK);
		repeat (2) @(negedge mclk);
		chk(irq_req, 1);
		repeat (6) @(negedge mclk);
		chk(irq_req, 0);
		// Watchdog failure: fast release reads as internal
		wr(OFS_MASK, 32'h1F, 4'hF, r);
		wr(OFS_CTRL, ctl(1, 0, 1), 4'hF, r);
		rd(OFS_STATUS, d, r);
		pulse(P_WD);
		@(negedge mclk);
		chk(rst_pin_oe, 1);
		chk(intr, 1);
		low = 1'b0;
		repeat (40)
		begin
			@(negedge mclk);
			low |= !sys_rst_n;
		end
		chk(low, 1);
		rd(OFS_STATUS, d, r);
		chk(d, ev(0, 1, 1, 0, 0));
		chk(intr, 0);
		rd(OFS_CTRL, d, r);
		chk(d, ctl(0, 0, 1));
		chk(nmi_req, 0);
		// Clock monitor failure with slow outside release: external
		slow <= 1'b1;
		pulse(P_CM);
		repeat (60) @(negedge mclk);
		rd(OFS_STATUS, d, r);
		chk(d, ev(1, 0, 0, 1, 0));
		slow <= 1'b0;
		nonmaskable_interrupt_line_src <= 1'b0;
		// Outside reset with the clock stopped: start-up state, external cause
		wr(OFS_CTRL, ctl(1, 1, 0), 4'hF, r);
		ext_rst <= 1'b1;
		repeat (8) @(posedge mclk);
		ext_rst <= 1'b0;
		repeat (8) @(negedge mclk);
		chk(sys_rst_n, 1);
		rd(OFS_CTRL, d, r);
		chk(d, ctl(RST_EDGE, RST_STOP, RST_CLKEN));
		rd(OFS_STATUS, d, r);
		chk(d, ev(0, 0, 0, 1, 0));
		// Edge mode, one source only; acknowledge clears the request
		wr(OFS_CTRL, ctl(1, 0, 1), 4'hF, r);
		pulse(P_GO);
		repeat (6) @(negedge mclk);
		chk(irq_req, 1);
		pulse(P_ACK);
		repeat (2) @(negedge mclk);
		chk(irq_req, 0);
		rd(OFS_STATUS, d, r);
		chk(d, ev(0, 0, 0, 0, 1));
		finish_test;
	end
endmodule : reset_clock_interrupt_pins_bench
`default_nettype wire
